/* verilog/ccs_pkg.sv */
// Package of register offsets, fields, resets and timing for the cell control settings sequencer.
package ccs_pkg;
   localparam int unsigned CLK_HZ          = 125000000;
   localparam int unsigned TICK_US         = 1;
   localparam int unsigned US_CYCLES       = CLK_HZ / 1000000 * TICK_US;
   localparam int unsigned OPEN_STEP_US    = 100;
   localparam int unsigned PERIOD_STEP_US  = 1000;

   localparam logic [7:0]  ADDR_LOOP       = 8'h00;
   localparam logic [7:0]  ADDR_CELIM      = 8'h04;
   localparam logic [7:0]  ADDR_CELL       = 8'h08;
   localparam logic [7:0]  ADDR_IRCTL      = 8'h0c;
   localparam logic [7:0]  ADDR_CIOPEN     = 8'h10;
   localparam logic [7:0]  ADDR_CIPERD     = 8'h14;
   localparam logic [7:0]  ADDR_CICORR     = 8'h18;
   localparam logic [7:0]  ADDR_DLY_OPEN   = 8'h1c;
   localparam logic [7:0]  ADDR_DLY_CLOSED = 8'h20;
   localparam logic [7:0]  ADDR_TRIG       = 8'h24;
   localparam logic [7:0]  ADDR_STATUS     = 8'h28;

   localparam logic [1:0]  MODE_POT        = 2'h0;
   localparam logic [1:0]  MODE_GALV       = 2'h1;
   localparam logic [1:0]  MODE_ZRA        = 2'h2;
   localparam logic [2:0]  BW_MAX          = 3'h5;
   localparam logic [14:0] CELIM_MIN       = 15'h01f4;
   localparam logic [14:0] CELIM_MAX       = 15'h7530;
   localparam logic [14:0] CELIM_RST       = 15'h7530;
   localparam logic [7:0]  CORR_MAX        = 8'hc8;
   localparam logic [7:0]  CORR_RST        = 8'h64;
   localparam logic [13:0] OPEN_MIN        = 14'h0001;
   localparam logic [13:0] OPEN_MAX        = 14'h2710;
   localparam logic [13:0] PERD_MIN        = 14'h0001;
   localparam logic [13:0] PERD_MAX        = 14'h2710;
   localparam logic [19:0] DLY_MAX         = 20'hf4240;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [3:0] {
      CCS_IDLE   = 4'b0001,
      CCS_OPEN   = 4'b0010,
      CCS_CLOSED = 4'b0100,
      CCS_WAIT   = 4'b1000
   } ccs_state_e;
endpackage

/* verilog/ccs_sequencer.sv */
// Control settings registers, current interrupt sequencer and scan trigger gating.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ccs_sequencer
   import ccs_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   input  wire logic [7:0]  s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   input  wire logic        ce_clamp_limiting,
   input  wire logic        panel_switch_in,
   input  wire logic        safety_switch_closed,
   input  wire logic        ext_trigger_edge,
   input  wire logic        panel_trigger,
   input  wire logic        line_zero_cross,
   input  wire logic        scan_done,
   output logic [1:0]       loop_mode_ff,
   output logic [5:0]       loop_bw_sel_ff,
   output logic             ce_limit_en_ff,
   output logic [14:0]      ce_limit_mv_ff,
   output logic             cell_enable_ff,
   output logic             enable_lamp_ff,
   output logic             ir_comp_en_ff,
   output logic             ir_comp_type_ff,
   output logic [11:0]      pf_amount_ff,
   output logic             interrupt_switch_closed_ff,
   output logic             sample_open_ff,
   output logic             sample_closed_ff,
   output logic [7:0]       ci_corr_pct_ff,
   output logic             scan_start_ff,
   output logic             scanning_ff
);
   logic [2:0]  bw_code_ff;
   logic [13:0] ci_open_ff;
   logic [13:0] ci_period_ff;
   logic [19:0] dly_open_ff;
   logic [19:0] dly_closed_ff;
   logic        armed_ff;
   logic        line_sync_ff;
   logic        sw_pending_ff;
   logic        aw_held_ff;
   logic        w_held_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        wr_go;
   logic        wr_bad;
   logic        sw_trig;
   logic        cell_connected;
   ccs_state_e  state_ff;
   ccs_state_e  nxt_state;
   logic [7:0]  us_div_ff;
   logic        us_tick;
   logic [19:0] us_cnt_ff;
   logic [23:0] per_cnt_ff;
   logic        per_wrap;
   logic        sampled_ff;

   function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Write channel: address and data are latched in either order.
   assign s_axil_awready = !aw_held_ff && !s_axil_bvalid;
   assign s_axil_wready  = !w_held_ff && !s_axil_bvalid;
   assign wr_go          = aw_held_ff && w_held_ff && !s_axil_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
      end else begin
         if (s_axil_awvalid && s_axil_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axil_awaddr;
         end else if (wr_go) begin
            aw_held_ff <= 1'b0;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= s_axil_wdata;
            wstrb_ff  <= s_axil_wstrb;
         end else if (wr_go) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // Values out of range in the strobed bytes are refused with SLVERR and the setting is kept; unstrobed bytes are written unchecked.
   always_comb begin
      logic [31:0] m;
      m = wr_merge(32'h0, wdata_ff, wstrb_ff);
      wr_bad = 1'b0;
      case (awaddr_ff)
         ADDR_LOOP:       wr_bad = (m[1:0] > MODE_ZRA) || (m[6:4] > BW_MAX);
         ADDR_CELIM:      wr_bad = (m[14:0] < CELIM_MIN) || (m[14:0] > CELIM_MAX);
         ADDR_CELL, ADDR_IRCTL, ADDR_TRIG: wr_bad = 1'b0;
         ADDR_CIOPEN:     wr_bad = (m[13:0] < OPEN_MIN) || (m[13:0] > OPEN_MAX);
         ADDR_CIPERD:     wr_bad = (m[13:0] < PERD_MIN) || (m[13:0] > PERD_MAX);
         ADDR_CICORR:     wr_bad = m[7:0] > CORR_MAX;
         ADDR_DLY_OPEN, ADDR_DLY_CLOSED: wr_bad = m[19:0] > DLY_MAX;
         default:         wr_bad = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_bvalid <= 1'b0;
         s_axil_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axil_bvalid <= 1'b1;
         s_axil_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axil_bready) begin
         s_axil_bvalid <= 1'b0;
      end
   end

   // Settings registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_mode_ff    <= MODE_POT;
         bw_code_ff      <= 3'h0;
         ce_limit_en_ff  <= 1'b0;
         ce_limit_mv_ff  <= CELIM_RST;
         cell_enable_ff  <= 1'b0;
         ir_comp_en_ff   <= 1'b0;
         ir_comp_type_ff <= 1'b0;
         pf_amount_ff    <= 12'h000;
         ci_open_ff      <= OPEN_MIN;
         ci_period_ff    <= PERD_MAX;
         ci_corr_pct_ff  <= CORR_RST;
         dly_open_ff     <= 20'h0;
         dly_closed_ff   <= 20'h0;
         line_sync_ff    <= 1'b0;
      end else if (wr_go && !wr_bad) begin
         case (awaddr_ff)
            ADDR_LOOP: begin
               loop_mode_ff <= wdata_ff[1:0];
               bw_code_ff   <= wdata_ff[6:4];
            end
            ADDR_CELIM: ce_limit_mv_ff <= wdata_ff[14:0];
            ADDR_CELL: begin
               cell_enable_ff <= wdata_ff[0];
               ce_limit_en_ff <= wdata_ff[4];
            end
            ADDR_IRCTL: begin
               ir_comp_en_ff   <= wdata_ff[0];
               ir_comp_type_ff <= wdata_ff[1];
               pf_amount_ff    <= wdata_ff[27:16];
            end
            ADDR_CIOPEN:     ci_open_ff     <= wdata_ff[13:0];
            ADDR_CIPERD:     ci_period_ff   <= wdata_ff[13:0];
            ADDR_CICORR:     ci_corr_pct_ff <= wdata_ff[7:0];
            ADDR_DLY_OPEN:   dly_open_ff    <= wdata_ff[19:0];
            ADDR_DLY_CLOSED: dly_closed_ff  <= wdata_ff[19:0];
            ADDR_TRIG:       line_sync_ff   <= wdata_ff[4];
            default: ;
         endcase
      end
   end

   // One-hot bandwidth select, bit 0 for the widest band.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_bw_sel_ff <= 6'h01;
      end else begin
         loop_bw_sel_ff <= 6'h01 << bw_code_ff;
      end
   end

   assign cell_connected = interrupt_switch_closed_ff && safety_switch_closed;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_lamp_ff <= 1'b0;
      end else begin
         enable_lamp_ff <= cell_enable_ff && panel_switch_in;
      end
   end

   // Read channel.
   assign s_axil_arready = !s_axil_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axil_rvalid <= 1'b0;
         s_axil_rdata  <= 32'h0;
         s_axil_rresp  <= RESP_OKAY;
      end else if (s_axil_arvalid && s_axil_arready) begin
         s_axil_rvalid <= 1'b1;
         s_axil_rresp  <= RESP_OKAY;
         case (s_axil_araddr)
            ADDR_LOOP:       s_axil_rdata <= {25'h0, bw_code_ff, 2'h0, loop_mode_ff};
            ADDR_CELIM:      s_axil_rdata <= {17'h0, ce_limit_mv_ff};
            ADDR_CELL:       s_axil_rdata <= {27'h0, ce_limit_en_ff, 3'h0, cell_enable_ff};
            ADDR_IRCTL:      s_axil_rdata <= {4'h0, pf_amount_ff, 14'h0, ir_comp_type_ff, ir_comp_en_ff};
            ADDR_CIOPEN:     s_axil_rdata <= {18'h0, ci_open_ff};
            ADDR_CIPERD:     s_axil_rdata <= {18'h0, ci_period_ff};
            ADDR_CICORR:     s_axil_rdata <= {24'h0, ci_corr_pct_ff};
            ADDR_DLY_OPEN:   s_axil_rdata <= {12'h0, dly_open_ff};
            ADDR_DLY_CLOSED: s_axil_rdata <= {12'h0, dly_closed_ff};
            ADDR_TRIG:       s_axil_rdata <= {27'h0, line_sync_ff, 3'h0, armed_ff};
            ADDR_STATUS:     s_axil_rdata <= {28'h0, scanning_ff, cell_connected,
                                              ce_limit_en_ff && ce_clamp_limiting, enable_lamp_ff};
            default: begin
               s_axil_rdata <= 32'h0;
               s_axil_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axil_rready) begin
         s_axil_rvalid <= 1'b0;
      end
   end

   // Trigger register: bit 0 arm, bit 8 software trigger (self-clearing).
   assign sw_trig = wr_go && !wr_bad && (awaddr_ff == ADDR_TRIG) && wdata_ff[8];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_ff      <= 1'b0;
         sw_pending_ff <= 1'b0;
         scan_start_ff <= 1'b0;
         scanning_ff   <= 1'b0;
      end else begin
         scan_start_ff <= 1'b0;
         if (armed_ff && ext_trigger_edge && !scanning_ff) begin
            armed_ff      <= 1'b0;
            scan_start_ff <= 1'b1;
            scanning_ff   <= 1'b1;
         end else if (wr_go && !wr_bad && awaddr_ff == ADDR_TRIG) begin
            armed_ff <= wdata_ff[0];
         end
         if (panel_trigger && !scanning_ff) begin
            scan_start_ff <= 1'b1;
            scanning_ff   <= 1'b1;
         end
         if ((sw_trig || sw_pending_ff) && !scanning_ff) begin
            if (!line_sync_ff || line_zero_cross) begin
               sw_pending_ff <= 1'b0;
               scan_start_ff <= 1'b1;
               scanning_ff   <= 1'b1;
            end else begin
               sw_pending_ff <= 1'b1;
            end
         end
         if (scan_done && scanning_ff) begin
            scanning_ff <= 1'b0;
         end
      end
   end

   // Microsecond tick and counters for the current interrupt sequencer.
   assign us_tick  = (us_div_ff == 8'(US_CYCLES - 1));
   assign per_wrap = us_tick && (per_cnt_ff >= 24'(ci_period_ff * PERIOD_STEP_US) - 24'h1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         us_div_ff <= 8'h00;
      end else begin
         // The divider rests while idle so that the first open interval is a whole number of microseconds.
         us_div_ff <= (us_tick || state_ff == CCS_IDLE) ? 8'h00 : us_div_ff + 8'h01;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         CCS_IDLE: if (ir_comp_en_ff && !ir_comp_type_ff) nxt_state = CCS_OPEN;
         CCS_OPEN: if (us_tick && us_cnt_ff >= 20'(ci_open_ff * OPEN_STEP_US) - 20'h1) nxt_state = CCS_CLOSED;
         CCS_CLOSED, CCS_WAIT: if (per_wrap) nxt_state = CCS_OPEN;
         default: nxt_state = CCS_IDLE;
      endcase
      if (!ir_comp_en_ff || ir_comp_type_ff) begin
         nxt_state = CCS_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff                   <= CCS_IDLE;
         us_cnt_ff                  <= 20'h0;
         per_cnt_ff                 <= 24'h0;
         sampled_ff                 <= 1'b0;
         sample_open_ff             <= 1'b0;
         sample_closed_ff           <= 1'b0;
         interrupt_switch_closed_ff <= 1'b1;
      end else begin
         state_ff         <= nxt_state;
         sample_open_ff   <= 1'b0;
         sample_closed_ff <= 1'b0;
         interrupt_switch_closed_ff <= (nxt_state != CCS_OPEN);
         if (nxt_state != state_ff) begin
            us_cnt_ff  <= 20'h0;
            sampled_ff <= 1'b0;
            if (state_ff == CCS_IDLE || per_wrap || nxt_state == CCS_IDLE) begin
               per_cnt_ff <= 24'h0;
            end else if (us_tick) begin
               per_cnt_ff <= per_cnt_ff + 24'h1;
            end
         end else if (state_ff != CCS_IDLE && us_tick) begin
            us_cnt_ff  <= us_cnt_ff + 20'h1;
            per_cnt_ff <= per_wrap ? 24'h0 : per_cnt_ff + 24'h1;
         end
         // A sample fires in the cycle after the first cycle in which the elapsed microseconds equal the delay.
         if (!sampled_ff && state_ff == CCS_OPEN && us_cnt_ff == dly_open_ff) begin
            sample_open_ff <= 1'b1;
            sampled_ff     <= 1'b1;
         end
         if (!sampled_ff && state_ff == CCS_CLOSED && us_cnt_ff == dly_closed_ff) begin
            sample_closed_ff <= 1'b1;
            sampled_ff       <= 1'b1;
         end
      end
   end

   chk_lamp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      enable_lamp_ff |-> $past(cell_enable_ff) && $past(panel_switch_in))
      else $error("lamp lit without enable and switch");
   chk_bw_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> loop_bw_sel_ff == (6'h01 << $past(bw_code_ff)))
      else $error("bandwidth select mismatch");
   chk_mode_legal: assert property (@(posedge aclk) disable iff (!aresetn)
      loop_mode_ff <= MODE_ZRA)
      else $error("illegal loop mode");
   chk_clamp_range: assert property (@(posedge aclk) disable iff (!aresetn)
      ce_limit_mv_ff >= CELIM_MIN && ce_limit_mv_ff <= CELIM_MAX)
      else $error("clamp magnitude out of range");
   chk_corr_range: assert property (@(posedge aclk) disable iff (!aresetn)
      ci_corr_pct_ff <= CORR_MAX)
      else $error("correction percent out of range");
   chk_arm_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      ext_trigger_edge && !armed_ff && !panel_trigger && !sw_trig && !sw_pending_ff |=> !scan_start_ff)
      else $error("unarmed external trigger started scan");
   chk_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      line_sync_ff && sw_pending_ff && !line_zero_cross && !panel_trigger
      && !(armed_ff && ext_trigger_edge) |=> !scan_start_ff)
      else $error("synced trigger started before zero crossing");
   chk_immediate: assert property (@(posedge aclk) disable iff (!aresetn)
      sw_trig && !line_sync_ff && !scanning_ff |=> scan_start_ff ##1 scanning_ff)
      else $error("unsynced trigger did not start at once");
   chk_switch_open: assert property (@(posedge aclk) disable iff (!aresetn)
      state_ff == CCS_OPEN |-> !interrupt_switch_closed_ff)
      else $error("switch closed in open state");
endmodule
`default_nettype wire

/* verification/ccs_panel_model.sv */
// Model of the panel side: power line zero crossings and scan completion.
`timescale 1ns/100ps
`default_nettype none
module ccs_panel_model #(
   parameter int ZC_CYCLES   = 400,
   parameter int SCAN_CYCLES = 20
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic scan_start_ff,
   output logic      line_zero_cross,
   output logic      scan_done
);
   int zc_cnt_ff;
   int scan_cnt_ff;
   always_ff @(posedge aclk) begin
      zc_cnt_ff       <= (!aresetn || zc_cnt_ff == ZC_CYCLES - 1) ? 0 : zc_cnt_ff + 1;
      line_zero_cross <= aresetn && zc_cnt_ff == ZC_CYCLES - 1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) scan_cnt_ff <= 0;
      else if (scan_start_ff) scan_cnt_ff <= SCAN_CYCLES;
      else if (scan_cnt_ff > 0) scan_cnt_ff <= scan_cnt_ff - 1;
      scan_done <= aresetn && scan_cnt_ff == 1;
   end
endmodule
`default_nettype wire

/* verification/cell_control_settings_sequencer_tb.sv */
// Register-level testbench of the cell control settings sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end
module cell_control_settings_sequencer_tb;
   import ccs_pkg::*;
   logic aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready;
   logic [7:0] s_axil_awaddr, s_axil_araddr;
   logic [31:0] s_axil_wdata, s_axil_rdata, rd;
   logic [3:0] s_axil_wstrb;
   logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
   logic [1:0] s_axil_bresp, s_axil_rresp, rr, loop_mode_ff;
   logic ce_clamp_limiting, panel_switch_in, safety_switch_closed, ext_trigger_edge, panel_trigger;
   logic line_zero_cross, scan_done, ce_limit_en_ff, cell_enable_ff, enable_lamp_ff, ir_comp_en_ff;
   logic ir_comp_type_ff, interrupt_switch_closed_ff, sample_open_ff, sample_closed_ff, scan_start_ff, scanning_ff;
   logic [5:0] loop_bw_sel_ff;
   logic [14:0] ce_limit_mv_ff;
   logic [11:0] pf_amount_ff;
   logic [7:0] ci_corr_pct_ff;
   logic sw_q;
   int err_count = 0, check_count = 0, n_start = 0, seq_cnt = 0, t_so = 0, t_cl = 0, t_sc = 0;

   ccs_sequencer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(s_axil_awaddr),
      .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
      .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready), .ce_clamp_limiting(ce_clamp_limiting), .panel_switch_in(panel_switch_in),
      .safety_switch_closed(safety_switch_closed), .ext_trigger_edge(ext_trigger_edge),
      .panel_trigger(panel_trigger), .line_zero_cross(line_zero_cross), .scan_done(scan_done),
      .loop_mode_ff(loop_mode_ff), .loop_bw_sel_ff(loop_bw_sel_ff), .ce_limit_en_ff(ce_limit_en_ff),
      .ce_limit_mv_ff(ce_limit_mv_ff), .cell_enable_ff(cell_enable_ff), .enable_lamp_ff(enable_lamp_ff),
      .ir_comp_en_ff(ir_comp_en_ff), .ir_comp_type_ff(ir_comp_type_ff), .pf_amount_ff(pf_amount_ff),
      .interrupt_switch_closed_ff(interrupt_switch_closed_ff), .sample_open_ff(sample_open_ff),
      .sample_closed_ff(sample_closed_ff), .ci_corr_pct_ff(ci_corr_pct_ff), .scan_start_ff(scan_start_ff),
      .scanning_ff(scanning_ff));

   ccs_panel_model i_panel (.aclk(aclk), .aresetn(aresetn), .scan_start_ff(scan_start_ff),
      .line_zero_cross(line_zero_cross), .scan_done(scan_done));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Timing of the interruption phases, counted from the opening of the switch.
   always @(posedge aclk) begin
      sw_q <= interrupt_switch_closed_ff;
      seq_cnt <= (sw_q === 1'b1 && interrupt_switch_closed_ff === 1'b0) ? 1 : seq_cnt + 1;
      if (sw_q === 1'b0 && interrupt_switch_closed_ff === 1'b1) t_cl <= seq_cnt;
      if (sample_open_ff === 1'b1) t_so <= seq_cnt;
      if (sample_closed_ff === 1'b1) t_sc <= seq_cnt;
      if (scan_start_ff === 1'b1) n_start <= n_start + 1;
   end

   function automatic logic near(input int v, input int e);
      return v >= e - 3 && v <= e + 3;
   endfunction

   task automatic print_verdict;
      if (err_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axil_awaddr  <= a;
      s_axil_wdata   <= d;
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid  <= 1'b1;
      s_axil_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
         if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
      end while (s_axil_bvalid !== 1'b1 && n < 200);
      s_axil_bready <= 1'b0;
      if (n >= 200) err_count++;
      `CHK("bresp", er, s_axil_bresp)
   endtask

   task automatic axr(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axil_araddr  <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
      end while (s_axil_rvalid !== 1'b1 && n < 200);
      s_axil_rready <= 1'b0;
      if (n >= 200) err_count++;
      rd = s_axil_rdata;
      rr = s_axil_rresp;
   endtask

   task automatic wait_zc;
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (line_zero_cross !== 1'b1 && n < 1000);
      if (n >= 1000) err_count++;
   endtask

   initial begin
      aresetn = 1'b0; s_axil_awvalid = 1'b0; s_axil_wvalid = 1'b0; s_axil_bready = 1'b0;
      s_axil_arvalid = 1'b0; s_axil_rready = 1'b0; s_axil_awaddr = 8'h00; s_axil_araddr = 8'h00;
      s_axil_wdata = 32'h0; s_axil_wstrb = 4'hf; ce_clamp_limiting = 1'b1; panel_switch_in = 1'b1;
      safety_switch_closed = 1'b1; ext_trigger_edge = 1'b0; panel_trigger = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      `CHK("bw_rst", 6'h01, loop_bw_sel_ff)
      `CHK("clamp_rst", 15'h7530, ce_limit_mv_ff)
      `CHK("corr_rst", 8'h64, ci_corr_pct_ff)
      for (int i = 0; i < 3; i++) begin
         axw(ADDR_LOOP, 32'(i), RESP_OKAY);
         `CHK("mode", 2'(i), loop_mode_ff)
      end
      axw(ADDR_LOOP, 32'h3, RESP_SLVERR);
      for (int i = 0; i < 6; i++) begin
         axw(ADDR_LOOP, 32'(i) << 4, RESP_OKAY);
         repeat (2) @(posedge aclk);
         `CHK("bw", 6'h01 << i, loop_bw_sel_ff)
      end
      axw(ADDR_LOOP, 32'h60, RESP_SLVERR);
      axw(ADDR_CELIM, 32'h1f3, RESP_SLVERR);
      axw(ADDR_CELIM, 32'h1f4, RESP_OKAY);
      axw(ADDR_CELIM, 32'h7531, RESP_SLVERR);
      `CHK("clamp", 15'h01f4, ce_limit_mv_ff)
      axw(ADDR_CELL, 32'h11, RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("limit_en", 1'b1, ce_limit_en_ff)
      `CHK("lamp", 1'b1, enable_lamp_ff)
      axr(ADDR_STATUS);
      `CHK("status_a", 32'h7, rd)
      panel_switch_in <= 1'b0;
      ce_clamp_limiting <= 1'b0;
      axr(ADDR_STATUS);
      `CHK("status_b", 32'h4, rd)
      ce_clamp_limiting <= 1'b1;
      safety_switch_closed <= 1'b0;
      axw(ADDR_CELL, 32'h1, RESP_OKAY);
      axr(ADDR_STATUS);
      `CHK("status_c", 32'h0, rd)
      `CHK("cell_en", 1'b1, cell_enable_ff)
      safety_switch_closed <= 1'b1;
      axw(ADDR_IRCTL, 32'h0fff0002, RESP_OKAY);
      `CHK("pf", 12'hfff, pf_amount_ff)
      `CHK("ir_type", 1'b1, ir_comp_type_ff)
      `CHK("ir_en", 1'b0, ir_comp_en_ff)
      axw(ADDR_CICORR, 32'hc8, RESP_OKAY);
      axw(ADDR_CICORR, 32'hc9, RESP_SLVERR);
      `CHK("corr", 8'hc8, ci_corr_pct_ff)
      axw(ADDR_CIOPEN, 32'h2711, RESP_SLVERR);
      axw(ADDR_CIOPEN, 32'h0, RESP_SLVERR);
      axw(ADDR_CIPERD, 32'h2711, RESP_SLVERR);
      axw(ADDR_CIPERD, 32'h0, RESP_SLVERR);
      axw(ADDR_DLY_CLOSED, 32'hf4241, RESP_SLVERR);
      axw(ADDR_DLY_CLOSED, 32'hf4240, RESP_OKAY);
      axr(ADDR_DLY_CLOSED);
      `CHK("dly_rd", 32'hf4240, rd)
      axw(8'h2c, 32'h1, RESP_SLVERR);
      axr(8'h2c);
      `CHK("unmapped_resp", RESP_SLVERR, rr)
      `CHK("unmapped_data", 32'h0, rd)
      @(posedge aclk) ext_trigger_edge <= 1'b1;
      @(posedge aclk) ext_trigger_edge <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHK("start_unarmed", 0, n_start)
      axw(ADDR_TRIG, 32'h1, RESP_OKAY);
      @(posedge aclk) ext_trigger_edge <= 1'b1;
      @(posedge aclk) ext_trigger_edge <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHK("start_armed", 1, n_start)
      `CHK("scanning", 1'b1, scanning_ff)
      repeat (30) @(posedge aclk);
      `CHK("scan_over", 1'b0, scanning_ff)
      axw(ADDR_TRIG, 32'h100, RESP_OKAY);
      repeat (6) @(posedge aclk);
      `CHK("start_sw", 2, n_start)
      repeat (30) @(posedge aclk);
      axw(ADDR_TRIG, 32'h10, RESP_OKAY);
      @(posedge aclk) panel_trigger <= 1'b1;
      @(posedge aclk) panel_trigger <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHK("start_panel", 3, n_start)
      repeat (30) @(posedge aclk);
      wait_zc();
      axw(ADDR_TRIG, 32'h110, RESP_OKAY);
      repeat (100) @(posedge aclk);
      `CHK("start_held", 3, n_start)
      wait_zc();
      repeat (6) @(posedge aclk);
      `CHK("start_zc", 4, n_start)
      axw(ADDR_CIPERD, 32'h2, RESP_OKAY);
      axw(ADDR_CIOPEN, 32'h1, RESP_OKAY);
      axw(ADDR_DLY_OPEN, 32'ha, RESP_OKAY);
      axw(ADDR_DLY_CLOSED, 32'h14, RESP_OKAY);
      axw(ADDR_IRCTL, 32'h1, RESP_OKAY);
      repeat (100) @(posedge aclk);
      axr(ADDR_STATUS);
      `CHK("status_open", 32'h0, rd)
      for (int n = 0; n < 20000 && t_sc == 0; n++) @(posedge aclk);
      `CHK("t_open_smp", 1'b1, near(t_so, 10 * US_CYCLES))
      `CHK("t_reclose", 1'b1, near(t_cl, OPEN_STEP_US * US_CYCLES))
      `CHK("t_closed_smp", 1'b1, near(t_sc - t_cl, 20 * US_CYCLES))
      axw(ADDR_IRCTL, 32'h0, RESP_OKAY);
      print_verdict();
   end

   initial begin
      #(40000 * 8);
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
